// ### bench/fpru_regfile_model.sv
// register-file side model: catches each result word on its strobe.
// assumes the rounder's one-cycle result strobe on the same clock.
module fpru_regfile_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // result from the rounder
    input wire logic i_valid,
    input fpru_pkg::fpru_res_s i_res,
    // captured entry
    output fpru_pkg::fpru_res_s o_entry
);
    timeunit 1ns;
    timeprecision 1ps;
    import fpru_pkg::*;
    // entry only written on the strobe, so a stray word shows up stale
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_entry <= '0;
        end else if (i_valid) begin
            o_entry <= i_res;
        end
    end
endmodule

// ### bench/fpru_rounding_unit_sva.sv
// checker for the rounding unit, watching its ports only.
// assumes one clock and a synchronous active-high reset.
module fpru_rounding_unit_sva (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // request side
    input wire logic i_valid,
    input fpru_pkg::fpru_req_s i_req,
    // result side
    input wire logic o_valid,
    input fpru_pkg::fpru_res_s o_res,
    input wire logic o_overflow,
    input wire logic o_underflow,
    input wire logic o_inexact_round_flag,
    input wire logic o_frac_incremented_flag,
    input wire logic o_flags_written
);
    timeunit 1ns;
    timeprecision 1ps;
    import fpru_pkg::*;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);

    // ----
    // properties
    // ----
    a_valid_latency: assert property (i_valid |-> ##2 o_valid)
        else $error("result strobe late or missing");
    a_valid_cause: assert property (o_valid |-> $past(i_valid, 2))
        else $error("result strobe without request");
    a_res_hold: assert property (!o_valid |-> $stable(o_res) &&
        $stable(o_overflow) && $stable(o_underflow))
        else $error("result moved without strobe");
    a_flags_hold: assert property (!o_flags_written |->
        $stable(o_inexact_round_flag) && $stable(o_frac_incremented_flag))
        else $error("status flags moved without write");
    a_write_capable: assert property (o_valid |-> o_flags_written ==
        ($past(i_req.op, 2) != OP_OTHER))
        else $error("flag write does not match op class");
    a_write_strobe: assert property (o_flags_written |-> o_valid)
        else $error("flag write outside result strobe");
    a_inc_inexact: assert property (o_frac_incremented_flag |->
        o_inexact_round_flag)
        else $error("increment flag without inexact flag");
    a_single_low: assert property (o_valid &&
        $past(i_req.prec, 2) == PREC_SGL |-> o_res.frac[28:0] == '0)
        else $error("single result has low bits set");
    a_ovf_inf: assert property (o_valid && o_overflow |->
        o_res.exp == EXP_INF && o_res.frac == '0)
        else $error("overflow result is not infinity");
    a_ovf_unf: assert property (o_valid |->
        !(o_overflow && o_underflow))
        else $error("overflow and underflow together");

    c_overflow: cover property (o_valid && o_overflow);
    c_underflow: cover property (o_valid && o_underflow);
    c_increment: cover property (o_flags_written && o_frac_incremented_flag);
endmodule

bind fpru_rounding_unit fpru_rounding_unit_sva u_sva (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_valid(i_valid),
    .i_req(i_req), .o_valid(o_valid), .o_res(o_res),
    .o_overflow(o_overflow), .o_underflow(o_underflow),
    .o_inexact_round_flag(o_inexact_round_flag),
    .o_frac_incremented_flag(o_frac_incremented_flag),
    .o_flags_written(o_flags_written)
);

// ### bench/tb_fpru_rounding_unit.sv
// bench for the rounding unit: directed rounding cases, grouped into five tasks.
// assumes results two edges after each request, inputs set on negedge.
module tb_fpru_rounding_unit;
    timeunit 1ns;
    timeprecision 1ps;
    import fpru_pkg::*;
    logic i_ref_clk, i_srst, i_valid;
    fpru_req_s i_req;
    logic o_valid, o_overflow, o_underflow, o_flags_written;
    logic o_inexact_round_flag, o_frac_incremented_flag;
    fpru_res_s o_res, entry;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;

    fpru_rounding_unit u_dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
        .i_valid(i_valid), .i_req(i_req), .o_valid(o_valid),
        .o_res(o_res), .o_overflow(o_overflow), .o_underflow(o_underflow),
        .o_inexact_round_flag(o_inexact_round_flag),
        .o_frac_incremented_flag(o_frac_incremented_flag),
        .o_flags_written(o_flags_written));
    fpru_regfile_model u_rf (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
        .i_valid(o_valid), .i_res(o_res), .o_entry(entry));

    initial begin
        i_ref_clk = 1'h0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // wide enough for strobe, result word and one flag together
    task automatic chk(input string s, input logic [65:0] got, exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", s, exp, got);
        end
    endtask

    function automatic fpru_acc_s mk(input logic s, l, input logic [51:0] f,
        input logic [2:0] grx, input logic [12:0] e);
        return '{s, 1'h0, l, f, grx[2], grx[1], grx[0], e};
    endfunction

    // entered on a negedge, returns on the negedge of the result strobe
    task automatic issue(input fpru_acc_s a, input fpru_mode_e m,
        input fpru_prec_e p, input fpru_op_e o);
        int n;
        i_req = '{a, m, p, o};
        i_valid = 1'h1;
        @(negedge i_ref_clk);
        i_valid = 1'h0;
        n = 1;
        while (o_valid !== 1'h1 && n < 8) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk("latency", 66'(n), 66'h2);
        chk("written", o_flags_written, o != OP_OTHER);
    endtask

    task automatic expect3(input fpru_res_s e, input logic inx, inc);
        @(posedge i_ref_clk);
        #1;
        chk("result", entry, e);
        chk("inexact", o_inexact_round_flag, inx);
        chk("incremented", o_frac_incremented_flag, inc);
        @(negedge i_ref_clk);
    endtask

    task automatic t_modes();
        logic s, inc, inx;
        logic [51:0] f;
        for (int m = 0; m < 4; m++) begin
            for (int g = 0; g < 16; g++) begin
                s = g[3];
                f = 52'h0_0000_0000_1230 | 52'(s ^ m[0]);
                inx = |g[2:0];
                case (m)
                    0: inc = g[2] && (g[1] || g[0] || f[0]);
                    1: inc = 1'h0;
                    2: inc = !s && inx;
                    default: inc = s && inx;
                endcase
                issue(mk(s, 1'h1, f, g[2:0], 13'h0000), fpru_mode_e'(m),
                    PREC_DBL, fpru_op_e'(1 + g % 3));
                expect3('{s, 11'h3ff, f + 52'(inc)}, inx, inc);
            end
        end
        $display("test modes done");
    endtask

    task automatic t_shapes();
        issue(mk(0, 1, 52'hf_ffff_ffff_ffff, 3'h6, 13'h0000), RM_NEAREST,
            PREC_DBL, OP_ARITH);
        expect3('{1'h0, 11'h400, 52'h0}, 1'h1, 1'h1);
        issue(mk(0, 0, 52'h8_0000_0000_0001, 3'h4, 13'h0000), RM_NEAREST,
            PREC_DBL, OP_MADD);
        expect3('{1'h0, 11'h3fe, 52'h0_0000_0000_0003}, 1'h0, 1'h0);
        issue(mk(0, 1, 52'h0_0000_3000_0001, 3'h0, 13'h0000), RM_NEAREST,
            PREC_SGL, OP_CONV);
        expect3('{1'h0, 11'h3ff, 52'h0_0000_4000_0000}, 1'h1, 1'h1);
        issue(mk(0, 1, 52'h0_0000_3000_0001, 3'h0, 13'h0000), RM_ZERO,
            PREC_SGL, OP_ARITH);
        expect3('{1'h0, 11'h3ff, 52'h0_0000_2000_0000}, 1'h1, 1'h0);
        $display("test shapes done");
    endtask

    task automatic t_limits();
        issue(mk(0, 1, 52'hf_ffff_ffff_ffff, 3'h4, 13'h03ff), RM_NEAREST,
            PREC_DBL, OP_ARITH);
        chk("overflow", o_overflow, 1'h1);
        expect3('{1'h0, 11'h7ff, 52'h0}, 1'h1, 1'h1);
        issue(mk(0, 1, 52'hf_ffff_ffff_ffff, 3'h3, 13'h03ff), RM_NEAREST,
            PREC_DBL, OP_ARITH);
        chk("overflow", o_overflow, 1'h0);
        expect3('{1'h0, 11'h7fe, 52'hf_ffff_ffff_ffff}, 1'h1, 1'h0);
        issue(mk(1, 1, 52'h0, 3'h0, 13'h1bc6), RM_ZERO, PREC_DBL, OP_ARITH);
        chk("underflow", o_underflow, 1'h1);
        expect3('{1'h1, 11'h000, 52'h0}, 1'h1, 1'h0);
        $display("test limits done");
    endtask

    task automatic t_other();
        logic [51:0] f;
        f = 52'h0_0000_0000_0010;
        issue(mk(0, 1, f, 3'h7, 13'h0000), RM_NEAREST, PREC_DBL, OP_ARITH);
        expect3('{1'h0, 11'h3ff, f + 52'h1}, 1'h1, 1'h1);
        issue(mk(0, 1, f, 3'h3, 13'h0000), RM_NEAREST, PREC_DBL, OP_OTHER);
        expect3('{1'h0, 11'h3ff, f}, 1'h1, 1'h1);
        issue(mk(0, 1, f, 3'h0, 13'h0000), RM_PINF, PREC_DBL, OP_CONV);
        expect3('{1'h0, 11'h3ff, f}, 1'h0, 1'h0);
        issue(mk(0, 1, f, 3'h7, 13'h0000), RM_PINF, PREC_DBL, OP_OTHER);
        expect3('{1'h0, 11'h3ff, f}, 1'h0, 1'h0);
        $display("test other done");
    endtask

    task automatic t_b2b();
        i_req = '{mk(0, 1, 52'h5, 3'h0, 13'h0000), RM_NEAREST, PREC_DBL,
            OP_ARITH};
        i_valid = 1'h1;
        @(negedge i_ref_clk);
        i_req.acc.frac = 52'h6;
        @(negedge i_ref_clk);
        i_valid = 1'h0;
        chk("first", {o_valid, o_res},
            {1'h1, 1'h0, 11'h3ff, 52'h5});
        @(negedge i_ref_clk);
        chk("second", {o_valid, o_res},
            {1'h1, 1'h0, 11'h3ff, 52'h6});
        i_srst = 1'h1;
        repeat (3) @(negedge i_ref_clk);
        chk("reset", {o_valid, o_res, o_inexact_round_flag}, 66'h0);
        i_srst = 1'h0;
        @(negedge i_ref_clk);
        // first request after a mid-run reset: tie with odd lsb
        issue(mk(0, 1, 52'h5, 3'h4, 13'h0000), RM_NEAREST, PREC_DBL,
            OP_ARITH);
        expect3('{1'h0, 11'h3ff, 52'h6}, 1'h1, 1'h1);
        $display("test back to back and reset done");
    endtask

    initial begin
        i_srst = 1'h1;
        i_valid = 1'h0;
        i_req = '0;
        repeat (5) @(negedge i_ref_clk);
        i_srst = 1'h0;
        @(negedge i_ref_clk);
        t_modes();
        t_shapes();
        t_limits();
        t_other();
        t_b2b();
        give_verdict();
    end
endmodule

// ### hdl/fpru_norm.sv
// combinational normaliser for the rounding accumulator.
// assumes the caller registers the result; emin picks the format range.
module fpru_norm (
    // accumulator in
    input fpru_pkg::fpru_acc_s i_acc,
    input wire logic [fpru_pkg::EXP_W-1:0] i_emin,
    // accumulator out, carry always clear
    output fpru_pkg::fpru_acc_s o_acc
);
    import fpru_pkg::*;

    // ----------------------------------------------------------------
    // leading zero count
    // ----------------------------------------------------------------
    function automatic int lead_zeros(input logic [SIG_W-1:0] v);
        int n;
        n = SIG_W;
        for (int i = 0; i < SIG_W; i++) begin
            if (v[i]) begin
                n = SIG_W - 1 - i;
            end
        end
        return n;
    endfunction

    // ----------------------------------------------------------------
    // shift
    // ----------------------------------------------------------------
    always_comb begin
        logic [SIG_W-1:0] v;
        logic [SIG_W-1:0] lost;
        logic sx;
        logic [EXP_W-1:0] e;
        int room;
        int sh;
        v = {i_acc.lead, i_acc.frac, i_acc.g, i_acc.r};
        lost = '0;
        sx = i_acc.x;
        e = i_acc.exp;
        room = 0;
        sh = 0;
        if (i_acc.carry) begin
            // carry out: one step right, bump exponent [RULE13]
            sx = sx | v[0]; // [RULE11]
            v = {1'b1, v[SIG_W-1:1]};
            e = e + EXP_ONE; // [RULE13]
        end else begin
            // stop at emin so denormals keep their form [RULE21]
            room = int'($signed(e)) - int'($signed(i_emin));
            sh = lead_zeros(v);
            if (room <= 0) begin
                sh = 0;
            end else if (sh > room) begin
                sh = room;
            end
            // guard and round move with it, zero into round [RULE12]
            v = v << sh;
            e = e - EXP_W'(sh);
        end
        if ($signed(e) < $signed(i_emin)) begin
            // denormalise, every bit lost goes to sticky [RULE21]
            sh = int'($signed(i_emin)) - int'($signed(e));
            if (sh >= SIG_W) begin
                lost = v;
                v = '0;
            end else begin
                lost = v & ~({SIG_W{1'b1}} << sh);
                v = v >> sh;
            end
            sx = sx | (|lost); // [RULE11]
            e = i_emin;
        end
        o_acc = '{sign: i_acc.sign, carry: 1'b0, lead: v[SIG_W-1],
                  frac: v[SIG_W-2:2], g: v[1], r: v[0], x: sx, exp: e};
    end

endmodule

// ### hdl/fpru_pkg.sv
// package for the floating-point rounding unit: widths, format limits,
// modes and the carriers between the arithmetic pipe and the rounder.
// assumes exponents arrive unbiased, two's complement, at EXP_W bits.
package fpru_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int DBL_EXP_W = 11;
    localparam int EXP_W = DBL_EXP_W + 2;
    localparam int FRAC_W = 52;
    localparam int SGL_FRAC_W = 23;
    localparam int SGL_LOW_W = FRAC_W - SGL_FRAC_W;
    localparam int SGL_GUARD_BIT = SGL_LOW_W - 1;
    localparam int SGL_ROUND_BIT = SGL_LOW_W - 2;
    // lead bit, fraction, guard and round
    localparam int SIG_W = FRAC_W + 3;
    localparam int SUM_W = FRAC_W + 2;

    // ----------------------------------------------------------------
    // format limits, unbiased; the bias and the eleven-bit special codes
    // ----------------------------------------------------------------
    localparam logic [EXP_W-1:0] DBL_EMIN = 13'h1C02;
    localparam logic [EXP_W-1:0] DBL_EMAX = 13'h03FF;
    localparam logic [EXP_W-1:0] SGL_EMIN = 13'h1F82;
    localparam logic [EXP_W-1:0] SGL_EMAX = 13'h007F;
    localparam logic [EXP_W-1:0] EXP_ONE = 13'h0001;
    localparam logic [DBL_EXP_W-1:0] DBL_BIAS = 11'h3FF;
    localparam logic [DBL_EXP_W-1:0] EXP_INF = 11'h7FF;
    localparam logic [DBL_EXP_W-1:0] EXP_ZERO = 11'h000;

    // ----------------------------------------------------------------
    // masks and units for the single and double rounding positions
    // ----------------------------------------------------------------
    localparam logic [FRAC_W-1:0] FRAC_ONES = {FRAC_W{1'b1}};
    localparam logic [FRAC_W-1:0] SGL_KEEP = FRAC_ONES << SGL_LOW_W;
    localparam logic [FRAC_W-1:0] SGL_STICKY =
        ~(FRAC_ONES << SGL_ROUND_BIT);
    localparam logic [SUM_W-1:0] DBL_UNIT = 54'h1;
    localparam logic [SUM_W-1:0] SGL_UNIT = DBL_UNIT << SGL_LOW_W;
    localparam logic [SUM_W-1:0] NO_UNIT = 54'h0;

    // ----------------------------------------------------------------
    // modes and classes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RM_NEAREST = 2'b00,
        RM_ZERO = 2'b01,
        RM_PINF = 2'b10,
        RM_MINF = 2'b11
    } fpru_mode_e;

    typedef enum logic {
        PREC_DBL = 1'b0,
        PREC_SGL = 1'b1
    } fpru_prec_e;

    typedef enum logic [1:0] {
        OP_OTHER = 2'b00,
        OP_ARITH = 2'b01,
        OP_MADD = 2'b10,
        OP_CONV = 2'b11
    } fpru_op_e;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sign;
        logic carry;
        logic lead;
        logic [FRAC_W-1:0] frac;
        logic g;
        logic r;
        logic x;
        logic [EXP_W-1:0] exp;
    } fpru_acc_s;

    typedef struct packed {
        fpru_acc_s acc;
        fpru_mode_e round_mode_field;
        fpru_prec_e prec;
        fpru_op_e op;
    } fpru_req_s;

    // double-format register word
    typedef struct packed {
        logic sign;
        logic [DBL_EXP_W-1:0] exp;
        logic [FRAC_W-1:0] frac;
    } fpru_res_s;

endpackage

// ### hdl/fpru_rounding_unit.sv
// floating-point rounding unit: two-stage pipe from the arithmetic
// pipe's accumulator to a double-format register word with flags.
// assumes requests come from logic on i_ref_clk, one per cycle at most.
//
// Function
// RULE1 - two-bit field picks one of four modes
// RULE2 - rounding sets inexact, increment sets incremented
// RULE3 - other instructions leave both flags alone
// RULE4 - round only capable ops, only when inexact
// RULE5 - exact value gives truncation in every mode
// RULE6 - toward zero picks smaller magnitude, truncation
// RULE7 - plus infinity larger, minus infinity smaller
// RULE8 - missing bound gives overflow or underflow
// RULE9 - exponent carries two bits beyond eleven
// RULE10 - accumulator: sign, carry, lead, fraction, GRX
// RULE11 - sticky ors every bit below round
// RULE12 - left shift moves guard, round; zeros in
// RULE13 - carry out shifts right, bumps exponent
// RULE14 - keep bits above position, zero below
// RULE15 - single: guard 24, round 25, sticky rest
// RULE16 - any nonzero guard, round, sticky: inexact
// RULE17 - nearest with guard clear truncates
// RULE18 - nearest, guard and round or sticky: increment
// RULE19 - nearest tie rounds to even
// RULE20 - nearest at max magnitude: infinity or max
// RULE21 - normalise or denormalise before rounding
// RULE22 - single in double form, result per precision
// RULE23 - single results keep low 29 bits zero
// RULE24 - valid strobe in, matching valid strobe out
module fpru_rounding_unit (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_srst,
    // request from the arithmetic pipe
    input wire logic i_valid,
    input fpru_pkg::fpru_req_s i_req,
    // result to the register file
    output logic o_valid,
    output fpru_pkg::fpru_res_s o_res,
    output logic o_overflow,
    output logic o_underflow,
    // status flags
    output logic o_inexact_round_flag,
    output logic o_frac_incremented_flag,
    output logic o_flags_written
);
    import fpru_pkg::*;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    function automatic logic [EXP_W-1:0] emin_of(input fpru_prec_e p);
        return (p == PREC_SGL) ? SGL_EMIN : DBL_EMIN;
    endfunction

    function automatic logic [EXP_W-1:0] emax_of(input fpru_prec_e p);
        return (p == PREC_SGL) ? SGL_EMAX : DBL_EMAX;
    endfunction

    // only these classes may round or touch the flags
    function automatic logic can_round(input fpru_op_e op);
        return (op == OP_ARITH) || (op == OP_MADD) || (op == OP_CONV);
    endfunction

    // increment decision on the magnitude
    function automatic logic round_up(input fpru_mode_e m,
                                      input logic sign,
                                      input logic gb,
                                      input logic rb,
                                      input logic sb,
                                      input logic lsb);
        logic up;
        up = 1'b0;
        case (m) // [RULE1]
            RM_NEAREST: begin
                // guard clear truncates [RULE17]
                // round or sticky with guard increments [RULE18]
                // tie goes to the even neighbour [RULE19]
                up = gb & (rb | sb | lsb);
            end
            RM_ZERO: begin
                up = 1'b0; // [RULE6]
            end
            RM_PINF: begin
                // larger bound is a bigger magnitude only if positive
                up = ~sign & (gb | rb | sb); // [RULE7]
            end
            RM_MINF: begin
                up = sign & (gb | rb | sb); // [RULE7]
            end
            default: begin
                up = 1'b0;
            end
        endcase
        return up;
    endfunction

    // ----------------------------------------------------------------
    // stage 1: normalise into the target range
    // ----------------------------------------------------------------
    fpru_acc_s norm1;
    fpru_acc_s s1_acc;
    fpru_mode_e s1_mode;
    fpru_prec_e s1_prec;
    fpru_op_e s1_op;
    logic s1_valid;

    // single operands already sit in double form [RULE22]
    fpru_norm u_norm_in (
        .i_acc(i_req.acc), // [RULE10]
        .i_emin(emin_of(i_req.prec)), // [RULE21]
        .o_acc(norm1)
    );

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            s1_valid <= 1'b0;
        end else begin
            s1_valid <= i_valid; // [RULE24]
        end
    end

    // data stage carries no reset; it is qualified by s1_valid
    always_ff @(posedge i_ref_clk) begin
        if (i_valid) begin
            s1_acc <= norm1;
            s1_mode <= i_req.round_mode_field;
            s1_prec <= i_req.prec;
            s1_op <= i_req.op;
        end
    end

    // ----------------------------------------------------------------
    // stage 2: round at the target position
    // ----------------------------------------------------------------
    logic [FRAC_W-1:0] keep;
    logic gb;
    logic rb;
    logic sb;
    logic lsb;
    logic cap;
    logic inexact;
    logic inc;
    logic [FRAC_W-1:0] trunc_frac;
    logic at_max;
    logic [SUM_W-1:0] sum;
    logic tiny;
    fpru_acc_s sum_acc;

    always_comb begin
        cap = can_round(s1_op);
        if (s1_prec == PREC_SGL) begin
            // single guard, round and sticky positions [RULE15]
            keep = SGL_KEEP;
            gb = s1_acc.frac[SGL_GUARD_BIT];
            rb = s1_acc.frac[SGL_ROUND_BIT];
            sb = (|(s1_acc.frac & SGL_STICKY)) | s1_acc.g | s1_acc.r
                 | s1_acc.x;
            lsb = s1_acc.frac[SGL_LOW_W];
        end else begin
            keep = FRAC_ONES;
            gb = s1_acc.g;
            rb = s1_acc.r;
            sb = s1_acc.x;
            lsb = s1_acc.frac[0];
        end
        // exact values never round [RULE4] [RULE5]
        inexact = cap & (gb | rb | sb); // [RULE16]
        inc = cap & round_up(s1_mode, s1_acc.sign, gb, rb, sb, lsb);
        // lower positions forced to zero [RULE14] [RULE23]
        trunc_frac = s1_acc.frac & keep;
        at_max = s1_acc.lead && ((trunc_frac | ~keep) == FRAC_ONES)
                 && (s1_acc.exp == emax_of(s1_prec));
        sum = {1'b0, s1_acc.lead, trunc_frac}
              + (inc ? ((s1_prec == PREC_SGL) ? SGL_UNIT : DBL_UNIT)
                     : NO_UNIT);
        // truncated magnitude of zero: the inward bound is missing
        tiny = inexact & ~inc & ~s1_acc.lead & (trunc_frac == '0);
        sum_acc = '{sign: s1_acc.sign, carry: sum[SUM_W-1],
                    lead: sum[SUM_W-2], frac: sum[FRAC_W-1:0],
                    g: 1'b0, r: 1'b0, x: 1'b0, exp: s1_acc.exp};
    end

    // ----------------------------------------------------------------
    // carry and re-normalise into double format
    // ----------------------------------------------------------------
    fpru_acc_s norm2;
    logic ovf;
    fpru_res_s next_res;

    // a single denormal is a normal double; double range renormalises it
    fpru_norm u_norm_out (
        .i_acc(sum_acc), // [RULE13]
        .i_emin(DBL_EMIN), // [RULE22]
        .o_acc(norm2)
    );

    always_comb begin
        // at max, nearest with guard set increments any capable op, so the
        // exponent steps past emax and infinity is stored [RULE20]
        ovf = $signed(norm2.exp) > $signed(emax_of(s1_prec)); // [RULE8]
        next_res.sign = norm2.sign;
        next_res.frac = norm2.frac;
        if (ovf) begin
            next_res.exp = EXP_INF;
            next_res.frac = '0;
        end else if (!norm2.lead) begin
            next_res.exp = EXP_ZERO;
        end else begin
            next_res.exp = norm2.exp[DBL_EXP_W-1:0] + DBL_BIAS; // [RULE9]
        end
    end

    // ----------------------------------------------------------------
    // result registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_valid <= 1'b0;
            o_res <= '0;
            o_overflow <= 1'b0;
            o_underflow <= 1'b0;
        end else begin
            o_valid <= s1_valid; // [RULE24]
            if (s1_valid) begin
                o_res <= next_res;
                o_overflow <= ovf | (inc & at_max); // [RULE8]
                o_underflow <= tiny; // [RULE8]
            end
        end
    end

    // ----------------------------------------------------------------
    // status flags
    // ----------------------------------------------------------------
    // held between writes: other instructions must not disturb them
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_inexact_round_flag <= 1'b0;
            o_frac_incremented_flag <= 1'b0;
            o_flags_written <= 1'b0;
        end else begin
            o_flags_written <= s1_valid & cap;
            if (s1_valid && cap) begin
                o_inexact_round_flag <= inexact; // [RULE2]
                o_frac_incremented_flag <= inc; // [RULE2]
            end // [RULE3]
        end
    end

endmodule
